//--- logic/fsr_status_word.sv
// 24-bit status and control word of a serial NOR flash with its acceptance checks.
// Assumes a command sequencer on clk hands over whole, decoded commands; pins are asynchronous.
// Behaviour
// - busy flag is 1 during program, erase or status write, else 0.
// - with write latch 0, status writes, programs and erases are refused.
// - area-guard bits select a region protected against program and erase.
// - area-guard bits change only when hardware protection is not active.
// - full erase runs only with three lower guards 1 and invert 1.
// - guard 00 accepts status writes whenever latch is 1, any pin level.
// - guard 01 locks status writes while protect pin is low and quad bit is 0.
// - guard 10 refuses all status writes until power cycle.
// - power cycle turns guard 10 into 00.
// - guard 11 refuses every status write until power cycle, which turns it into 00.
// - quad bit defaults 0; when 1 protect and pause pins become data lanes.
// - three secure-lock bits default 0, set individually, cleared only by power cycle.
// - invert bit defaults 0 and with guards selects the protected region.
// - suspend sets erase-paused or program-paused depending on operation.
// - resume, software reset pair and power cycle clear both paused flags.
// - drive field 00 full, 01 three quarters, 10 half default, 11 quarter.
// - pin-function bit 0 makes shared pin pause, 1 makes it reset.
// - quad bit 1 disables pause and reset on the shared pin.
// - low-power flag defaults 0; 1 shows low-power state.
// - write latch set by unlock; cleared by disable, writes, programs, erases.
// - guarded region stays readable but cannot be programmed or erased.
`timescale 1ns/100ps
`default_nettype none

module fsr_status_word
    import fsr_pkg::*;
#(
    parameter int SRW_CYCLES = 16
) (
    // Clock and power-cycle reset
    input wire logic clk,
    input wire logic rst_n,
    // Decoded command from the sequencer
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_aligned,
    input wire logic [23:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    // Array engine
    input wire logic op_done,
    // Package pins, asynchronous
    input wire logic wp_n_pin,
    input wire logic shared_n_pin,
    // Register contents and controls
    output fsr_word_t status_word,
    output logic busy_flag,
    output logic write_latch,
    output logic quad_lane_switch,
    output logic [1:0] drive_strength,
    output logic [2:0] secure_lock,
    output logic low_power_state,
    output logic pause_enable,
    output logic reset_enable,
    output logic pause_active,
    // Operation start pulses, array-running level and soft reset
    output logic prog_start,
    output logic erase_start,
    output logic chip_wipe_start,
    output logic array_run,
    output logic soft_reset
);
    generate
        if (SRW_CYCLES < 1 || SRW_CYCLES > 65535) begin : g_bad_srw
            $error("SRW_CYCLES must lie in 1..65535");
        end
    endgenerate

    fsr_op_t op_kind;
    logic [4:0] area_guard;
    logic [1:0] status_guard;
    logic protect_invert;
    logic erase_paused;
    logic program_paused;
    logic pin_function;
    logic low_power_flag;
    logic reset_armed;
    logic [15:0] srw_cnt;
    wire [1:0] pin_sync;

    // Two-stage synchronisers for the protect pin and the shared pin
    wire [1:0] pin_raw = {shared_n_pin, wp_n_pin};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            logic meta;
            logic sync;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta <= 1'b1;
                    sync <= 1'b1;
                end else begin
                    meta <= pin_raw[gi];
                    sync <= meta;
                end
            end
            // Only the second stage leaves the loop
            assign pin_sync[gi] = sync;
        end
    endgenerate

    // With quad lanes on, the protect pin carries data and cannot lock the word
    wire wp_high = quad_lane_switch | pin_sync[0];
    assign pause_enable = ~quad_lane_switch & ~pin_function;
    assign reset_enable = ~quad_lane_switch & pin_function;
    assign pause_active = pause_enable & ~pin_sync[1];
    wire pin_reset = reset_enable & ~pin_sync[1];

    // Command decode
    wire cmd_ok = cmd_valid & cmd_aligned;
    wire is_write_unlock_cmd = cmd_ok & (cmd_code == `FSR_CMD_WRITE_UNLOCK_CMD);
    wire is_wrdi = cmd_ok & (cmd_code == `FSR_CMD_WRDI);
    wire is_srw1 = cmd_ok & (cmd_code == `FSR_CMD_SRW1);
    wire is_srw2 = cmd_ok & (cmd_code == `FSR_CMD_SRW2);
    wire is_srw3 = cmd_ok & (cmd_code == `FSR_CMD_SRW3);
    wire is_srw = is_srw1 | is_srw2 | is_srw3;
    wire is_page = cmd_ok & ((cmd_code == `FSR_CMD_PAGE) | (cmd_code == `FSR_CMD_QPAGE));
    wire is_sect = cmd_ok & ((cmd_code == `FSR_CMD_SECT) | (cmd_code == `FSR_CMD_BLK32) |
                             (cmd_code == `FSR_CMD_BLK64));
    wire is_chip = cmd_ok & ((cmd_code == `FSR_CMD_CHIP1) | (cmd_code == `FSR_CMD_CHIP2));
    wire is_susp = cmd_ok & (cmd_code == `FSR_CMD_SUSP);
    wire is_resume = cmd_ok & (cmd_code == `FSR_CMD_RESUME);
    wire is_rsten = cmd_ok & (cmd_code == `FSR_CMD_RSTEN);
    wire is_rst = cmd_ok & (cmd_code == `FSR_CMD_RST);

    // Protected-region lookup
    fsr_prot_if prot ();
    assign prot.area_guard = area_guard;
    assign prot.protect_invert = protect_invert;
    assign prot.addr = cmd_addr;
    fsr_region_dec u_region (
        .pq (prot.dec)
    );

    // Acceptance
    wire idle = (op_kind == FSR_OP_IDLE);
    wire guard_open = (status_guard == `FSR_SG_OPEN) |
                      ((status_guard == `FSR_SG_PIN) & wp_high);
    wire srw_go = is_srw & write_latch & idle & guard_open;
    wire page_go = is_page & write_latch & idle & ~prot.hit;
    wire sect_go = is_sect & write_latch & idle & ~prot.hit;
    wire chip_go = is_chip & write_latch & idle &
                   (area_guard[2:0] == `FSR_AG_ALL) & protect_invert;
    // Any whole write-type command taken while idle consumes the latch, even if refused
    wire latch_use = idle & (is_srw | is_page | is_sect | is_chip);
    wire sw_reset = is_rst & reset_armed;
    wire vol_reset = sw_reset | pin_reset;
    wire srw_last = (op_kind == FSR_OP_SRW) & (srw_cnt == 16'h0000);
    wire array_done = op_done & ((op_kind == FSR_OP_PROG) | (op_kind == FSR_OP_ERASE));
    wire susp_prog = is_susp & (op_kind == FSR_OP_PROG);
    wire susp_erase = is_susp & (op_kind == FSR_OP_ERASE);
    wire resume_go = is_resume & idle & (erase_paused | program_paused);

    // Status-write busy countdown; holds at zero once spent
    wire srw_spent = (srw_cnt == 16'h0000);
    wire [15:0] next_srw_cnt = srw_go ? 16'(SRW_CYCLES - 1) :
                               (srw_spent ? srw_cnt : srw_cnt - 16'h0001);

    // Operation state
    fsr_op_t next_op_kind;
    always_comb begin
        next_op_kind = op_kind;
        unique case (op_kind)
            FSR_OP_IDLE: begin
                if (srw_go) begin
                    next_op_kind = FSR_OP_SRW;
                end else if (page_go) begin
                    next_op_kind = FSR_OP_PROG;
                end else if (sect_go | chip_go) begin
                    next_op_kind = FSR_OP_ERASE;
                end else if (resume_go) begin
                    // A program paused inside an erase suspend resumes in place of the erase
                    next_op_kind = program_paused ? FSR_OP_PROG : FSR_OP_ERASE;
                end
            end
            FSR_OP_PROG, FSR_OP_ERASE: begin
                if (array_done | is_susp) begin
                    next_op_kind = FSR_OP_IDLE;
                end
            end
            FSR_OP_SRW: begin
                if (srw_last) begin
                    next_op_kind = FSR_OP_IDLE;
                end
            end
        endcase
        if (vol_reset) begin
            next_op_kind = FSR_OP_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_kind <= FSR_OP_IDLE;
            srw_cnt <= 16'h0000;
        end else begin
            op_kind <= next_op_kind;
            srw_cnt <= next_srw_cnt;
        end
    end

    assign busy_flag = ~idle;
    assign array_run = (op_kind == FSR_OP_PROG) | (op_kind == FSR_OP_ERASE);

    // Volatile flags
    wire next_latch = is_write_unlock_cmd | (write_latch & ~is_wrdi & ~latch_use);
    wire next_epause = ~vol_reset & ~is_resume & (erase_paused | susp_erase);
    wire next_ppause = ~vol_reset & ~is_resume & (program_paused | susp_prog);
    wire next_armed = is_rsten | (reset_armed & ~cmd_ok);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_latch <= 1'b0;
            erase_paused <= 1'b0;
            program_paused <= 1'b0;
            reset_armed <= 1'b0;
        end else begin
            write_latch <= next_latch & ~vol_reset;
            erase_paused <= next_epause;
            program_paused <= next_ppause;
            reset_armed <= next_armed & ~vol_reset;
        end
    end

    // Written fields; those of the written byte land at once when the write is accepted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            area_guard <= `FSR_AG_RESET;
            status_guard <= `FSR_SG_OPEN;
            quad_lane_switch <= 1'b0;
            secure_lock <= `FSR_LOCK_RESET;
            protect_invert <= 1'b0;
            drive_strength <= `FSR_DRV_DEFAULT;
            pin_function <= 1'b0;
            low_power_flag <= 1'b0;
        end else if (srw_go) begin
            if (is_srw1) begin
                area_guard <= cmd_data[`FSR_B0_AG_HI:`FSR_B0_AG_LO];
                status_guard[0] <= cmd_data[`FSR_B0_SG0];
            end
            if (is_srw2) begin
                status_guard[1] <= cmd_data[`FSR_B1_SG1];
                quad_lane_switch <= cmd_data[`FSR_B1_QUAD];
                // Lock bits only ever gain ones
                secure_lock <= secure_lock | cmd_data[`FSR_B1_LOCK_HI:`FSR_B1_LOCK_LO];
                protect_invert <= cmd_data[`FSR_B1_INV];
            end
            if (is_srw3) begin
                pin_function <= cmd_data[`FSR_B2_PINF];
                drive_strength <= cmd_data[`FSR_B2_DRV_HI:`FSR_B2_DRV_LO];
                low_power_flag <= cmd_data[`FSR_B2_LPF];
            end
        end
    end

    assign low_power_state = low_power_flag;

    // Start pulses to the array engine and the reset pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_start <= 1'b0;
            erase_start <= 1'b0;
            chip_wipe_start <= 1'b0;
            soft_reset <= 1'b0;
        end else begin
            prog_start <= page_go;
            erase_start <= sect_go | chip_go;
            chip_wipe_start <= chip_go;
            soft_reset <= vol_reset;
        end
    end

    // Read view; reserved positions stay zero
    always_comb begin
        status_word = '0;
        status_word[`FSR_BIT_BUSY] = busy_flag;
        status_word[`FSR_BIT_LATCH] = write_latch;
        status_word[`FSR_AG_HI:`FSR_AG_LO] = area_guard;
        status_word[`FSR_BIT_SG0] = status_guard[0];
        status_word[`FSR_BIT_SG1] = status_guard[1];
        status_word[`FSR_BIT_QUAD] = quad_lane_switch;
        status_word[`FSR_BIT_PPAUSE] = program_paused;
        status_word[`FSR_LOCK_HI:`FSR_LOCK_LO] = secure_lock;
        status_word[`FSR_BIT_INV] = protect_invert;
        status_word[`FSR_BIT_EPAUSE] = erase_paused;
        status_word[`FSR_BIT_LPF] = low_power_flag;
        status_word[`FSR_DRV_HI:`FSR_DRV_LO] = drive_strength;
        status_word[`FSR_BIT_PINF] = pin_function;
    end
endmodule : fsr_status_word

`default_nettype wire

//--- logic/fsr_params.svh
// Constants of the flash status and control word: bit positions, command codes, reset values.
// Assumes inclusion by bare name from the package only; the design modules use its macros without including it.
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// Bit positions inside the 24-bit word
`define FSR_BIT_BUSY 0
`define FSR_BIT_LATCH 1
`define FSR_AG_LO 2
`define FSR_AG_HI 6
`define FSR_BIT_SG0 7
`define FSR_BIT_SG1 8
`define FSR_BIT_QUAD 9
`define FSR_BIT_PPAUSE 10
`define FSR_LOCK_LO 11
`define FSR_LOCK_HI 13
`define FSR_BIT_INV 14
`define FSR_BIT_EPAUSE 15
`define FSR_BIT_LPF 18
`define FSR_DRV_LO 21
`define FSR_DRV_HI 22
`define FSR_BIT_PINF 23
`define FSR_WORD_W 24

// Positions inside a written data byte
`define FSR_B0_AG_LO 2
`define FSR_B0_AG_HI 6
`define FSR_B0_SG0 7
`define FSR_B1_SG1 0
`define FSR_B1_QUAD 1
`define FSR_B1_LOCK_LO 3
`define FSR_B1_LOCK_HI 5
`define FSR_B1_INV 6
`define FSR_B2_LPF 2
`define FSR_B2_DRV_LO 5
`define FSR_B2_DRV_HI 6
`define FSR_B2_PINF 7

// Command codes
`define FSR_CMD_WRITE_UNLOCK_CMD 8'h06
`define FSR_CMD_WRDI 8'h04
`define FSR_CMD_SRW1 8'h01
`define FSR_CMD_SRW2 8'h31
`define FSR_CMD_SRW3 8'h11
`define FSR_CMD_PAGE 8'h02
`define FSR_CMD_QPAGE 8'h32
`define FSR_CMD_SECT 8'h20
`define FSR_CMD_BLK32 8'hD8
`define FSR_CMD_BLK64 8'h52
`define FSR_CMD_CHIP1 8'h60
`define FSR_CMD_CHIP2 8'hC7
`define FSR_CMD_SUSP 8'h75
`define FSR_CMD_RESUME 8'h7A
`define FSR_CMD_RSTEN 8'h66
`define FSR_CMD_RST 8'h99

// Reset values and guard codes
`define FSR_DRV_DEFAULT 2'h2
`define FSR_SG_OPEN 2'h0
`define FSR_SG_PIN 2'h1
`define FSR_AG_RESET 5'h00
`define FSR_LOCK_RESET 3'h0
`define FSR_AG_ALL 3'h7
`define FSR_AG_NONE 3'h0

// Protected-region size exponents
`define FSR_BIG_LOG2_BASE 5'h11
`define FSR_SMALL_LOG2_BASE 5'h0B
`define FSR_SMALL_LOG2_MAX 5'h0F
`define FSR_SMALL_CAP 3'h4

`endif

//--- logic/fsr_pkg.sv
// Types shared by the status-word block and its protected-region decoder.
// Assumes fsr_params.svh is on the include path.
`include "fsr_params.svh"

package fsr_pkg;
    typedef enum logic [1:0] {
        FSR_OP_IDLE,
        FSR_OP_PROG,
        FSR_OP_ERASE,
        FSR_OP_SRW
    } fsr_op_t;

    typedef logic [`FSR_WORD_W-1:0] fsr_word_t;
endpackage : fsr_pkg

//--- logic/fsr_prot_if.sv
// Carrier between the status-word block and the protected-region decoder.
// Assumes both ends run on the same clock; the decode is purely combinational.
`timescale 1ns/100ps
`default_nettype none

interface fsr_prot_if;
    logic [4:0] area_guard;
    logic protect_invert;
    logic [23:0] addr;
    logic hit;

    modport ctrl (output area_guard, output protect_invert, output addr, input hit);
    modport dec (input area_guard, input protect_invert, input addr, output hit);
endinterface : fsr_prot_if

`default_nettype wire

//--- logic/fsr_region_dec.sv
// Decides whether an address lies in the region guarded by the area-guard and invert bits.
// Assumes a 24-bit byte address into a 16 MB array.
`timescale 1ns/100ps
`default_nettype none

module fsr_region_dec
    import fsr_pkg::*;
(
    // Region query
    fsr_prot_if.dec pq
);
    wire [2:0] size_code = pq.area_guard[2:0];
    wire small_mode = pq.area_guard[4];
    wire lower_side = pq.area_guard[3];
    wire [2:0] capped = (size_code > `FSR_SMALL_CAP) ? `FSR_SMALL_CAP : size_code;
    // Large regions grow from 256 KB, small ones from 4 KB and stop at 32 KB
    wire [4:0] size_log2 = small_mode ? (`FSR_SMALL_LOG2_BASE + {2'h0, capped})
                                      : (`FSR_BIG_LOG2_BASE + {2'h0, size_code});
    wire [23:0] lower_rest = pq.addr >> size_log2;
    wire [23:0] upper_rest = (~pq.addr) >> size_log2;
    wire in_part = lower_side ? (lower_rest == 24'h000000) : (upper_rest == 24'h000000);
    wire plain_hit = (size_code == `FSR_AG_ALL) ? 1'b1 :
                     (size_code == `FSR_AG_NONE) ? 1'b0 : in_part;

    assign pq.hit = plain_hit ^ pq.protect_invert;
endmodule : fsr_region_dec

`default_nettype wire

//--- bench/fsr_status_word_assertions.sv
// Concurrent checks on the status word block, seeing only its ports.
// Assumes a bind from the bench; one clock domain with reset rst_n.
`timescale 1ns/100ps
`default_nettype none

module fsr_status_word_assertions
    import fsr_pkg::*;
#(
    parameter int SRW_CYCLES = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Command and pin inputs
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_aligned,
    input wire logic [23:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    input wire logic op_done,
    input wire logic wp_n_pin,
    input wire logic shared_n_pin,
    // Design outputs
    input wire fsr_word_t status_word,
    input wire logic busy_flag,
    input wire logic write_latch,
    input wire logic quad_lane_switch,
    input wire logic [1:0] drive_strength,
    input wire logic [2:0] secure_lock,
    input wire logic low_power_state,
    input wire logic pause_enable,
    input wire logic reset_enable,
    input wire logic pause_active,
    input wire logic prog_start,
    input wire logic erase_start,
    input wire logic chip_wipe_start,
    input wire logic array_run,
    input wire logic soft_reset
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    wire logic [1:0] sg_code = status_word[8:7];

    sequence took(logic [7:0] c);
        cmd_valid && cmd_aligned && cmd_code == c;
    endsequence
    // The pin passes two flops, so three low samples make the lock certain
    sequence pin_low;
        !wp_n_pin [*3];
    endsequence

    AST_LATCH_SET: assert property (took(8'h06) ##0 !busy_flag |=> write_latch)
        else $error("unlock left the write latch clear");
    AST_LATCH_DROP: assert property (took(8'h04) ##0 !busy_flag |=> !write_latch)
        else $error("disable left the write latch set");
    AST_NO_LATCH: assert property (took(8'h02) ##0 !write_latch
        |=> !prog_start && !busy_flag)
        else $error("program started without write latch");
    AST_SRW_BUSY: assert property (took(8'h01)
        ##0 (write_latch && !busy_flag && sg_code == 2'h0)
        |=> busy_flag && !write_latch ##1 busy_flag ##[1:40] !busy_flag)
        else $error("status write busy window wrong");
    AST_START_BUSY: assert property (prog_start || erase_start || chip_wipe_start
        |-> busy_flag)
        else $error("operation started without busy");
    AST_CHIP_GUARD: assert property (chip_wipe_start |-> $past(status_word[4:2]) == 3'h7
        && $past(status_word[14]))
        else $error("chip erase ran with wrong guard bits");
    AST_GUARD_LOCK: assert property (took(8'h01) ##0 status_word[8]
        |=> $stable(status_word[8:2]))
        else $error("status write accepted under lock-down");
    AST_PIN_LOCK: assert property (pin_low ##0 took(8'h01)
        ##0 (sg_code == 2'h1 && !quad_lane_switch) |=> $stable(status_word[8:2]))
        else $error("status write accepted with protect pin low");
    AST_LOCK_KEEP: assert property (($past(secure_lock) & ~secure_lock) == 3'h0)
        else $error("secure lock bit cleared");
    AST_PIN_FUNC: assert property (
        pause_enable == (!quad_lane_switch && !status_word[23])
        && reset_enable == (!quad_lane_switch && status_word[23]))
        else $error("shared pin function wrong");
    AST_RESERVED: assert property (status_word[20:19] == 2'h0
        && status_word[17:16] == 2'h0)
        else $error("reserved bits not zero");
    AST_SUSPEND: assert property (took(8'h75) ##0 array_run
        |=> !busy_flag && (status_word[10] || status_word[15]))
        else $error("suspend did not pause");
    AST_RESUME: assert property (took(8'h7A) ##0 !busy_flag
        |=> !status_word[15] && !status_word[10])
        else $error("resume left a paused flag");
    // The host hands commands over two cycles apart, so 99 follows 66 directly
    AST_SOFT_RST: assert property (took(8'h66) ##2 took(8'h99)
        |=> !status_word[15] && !status_word[10] && !write_latch ##[0:1] soft_reset)
        else $error("software reset incomplete");
endmodule : fsr_status_word_assertions

`default_nettype wire

//--- bench/fsr_host_model.sv
// Host controller model handing whole decoded commands to the status word block.
// Assumes the caller sits just after a clock edge; requests start gap+1 edges later.
`timescale 1ns/100ps
`default_nettype none

module fsr_host_model (
    // Clock
    input wire logic clk,
    // Decoded command
    output logic cmd_valid = 1'b0,
    output logic [7:0] cmd_code = 8'h00,
    output logic cmd_aligned = 1'b0,
    output logic [23:0] cmd_addr = 24'h000000,
    output logic [7:0] cmd_data = 8'h00
);
    task automatic send(input logic [7:0] code, input logic [23:0] addr,
                        input logic [7:0] data, input logic al, input int gap);
        repeat (gap + 1) @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_aligned <= al;
        cmd_addr <= addr;
        cmd_data <= data;
        @(posedge clk);
        // Released fields turn over so a stale value is never read as live
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        cmd_aligned <= ~al;
        cmd_addr <= ~addr;
        cmd_data <= ~data;
    endtask : send
endmodule : fsr_host_model

`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the status word block driven by the host model.
// Assumes logic/ compiled first; status write busy time shortened to two cycles.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("[ERR] %s exp %0h got %0h", n, e, g); \
    end \
end

module testbench
    import fsr_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_done = 1'b0;
    logic wp_n_pin = 1'b1;
    logic shared_n_pin = 1'b1;
    logic cmd_valid, cmd_aligned;
    logic [7:0] cmd_code, cmd_data;
    logic [23:0] cmd_addr;
    fsr_word_t status_word;
    logic busy_flag, write_latch, quad_lane_switch, low_power_state;
    logic [1:0] drive_strength;
    logic [2:0] secure_lock;
    logic pause_enable, reset_enable, pause_active, array_run, soft_reset;
    logic prog_start, erase_start, chip_wipe_start;
    int checks = 0;
    int err_total = 0;
    int cyc = 0;

    always #2.5 clk = ~clk;

    fsr_host_model host (.clk, .cmd_valid, .cmd_code, .cmd_aligned, .cmd_addr, .cmd_data);
    fsr_status_word #(.SRW_CYCLES(2)) uut (.clk, .rst_n, .cmd_valid, .cmd_code, .cmd_aligned,
        .cmd_addr, .cmd_data, .op_done, .wp_n_pin, .shared_n_pin, .status_word, .busy_flag,
        .write_latch, .quad_lane_switch, .drive_strength, .secure_lock, .low_power_state,
        .pause_enable, .reset_enable, .pause_active, .prog_start, .erase_start,
        .chip_wipe_start, .array_run, .soft_reset);

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    // Returns just after the edge where the command's effect is visible
    task automatic cmd(input logic [7:0] c, input logic [7:0] d = 8'h00,
                       input logic [23:0] a = 24'h000000, input logic al = 1'b1, input int g = 0);
        host.send(c, a, d, al, g);
        #1;
    endtask : cmd

    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        int n;
        n = 0;
        cmd(8'h06);
        cmd(c, d);
        while (busy_flag !== 1'b0 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("idle", 1'b1, n < 50)
    endtask : wr

    task automatic pin(input logic v);
        @(posedge clk);
        wp_n_pin <= v;
        repeat (3) @(posedge clk);
        #1;
    endtask : pin

    task automatic pwr();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask : pwr

    task automatic done_op();
        @(posedge clk);
        op_done <= 1'b1;
        @(posedge clk);
        op_done <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("op_done", 1'b0, busy_flag)
    endtask : done_op

    task automatic s_defaults();
        `CHK("word", 24'h400000, status_word)
        @(posedge clk);
        shared_n_pin <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK("pause_act", 2'h3, {pause_enable, pause_active})
        @(posedge clk);
        shared_n_pin <= 1'b1;
    endtask : s_defaults

    task automatic s_latch();
        cmd(8'h06, 8'h00, 24'h000000, 1'b0);
        `CHK("latch_misal", 1'b0, write_latch)
        cmd(8'h06);
        `CHK("latch_set", 1'b1, write_latch)
        cmd(8'h04, 8'h00, 24'h000000, 1'b1, 4);
        `CHK("latch_clr", 1'b0, write_latch)
        cmd(8'h02, 8'h00, 24'h001000);
        `CHK("prog_nolatch", 1'b0, prog_start)
        cmd(8'h01, 8'h1C);
        `CHK("srw_nolatch", 5'h00, status_word[6:2])
    endtask : s_latch

    task automatic s_protect();
        cmd(8'h06);
        cmd(8'h01, 8'h1C);
        `CHK("srw_busy", 2'h2, {busy_flag, write_latch})
        repeat (2) @(posedge clk);
        #1;
        `CHK("srw_idle", 6'h07, {busy_flag, status_word[6:2]})
        cmd(8'h06);
        cmd(8'h60);
        `CHK("chip_noinv", 1'b0, chip_wipe_start)
        cmd(8'h06);
        cmd(8'h02, 8'h00, 24'h000100);
        `CHK("prog_prot", 2'h0, {prog_start, write_latch})
        wr(8'h31, 8'h48);
        `CHK("inv_lock", 4'h9, {status_word[14], secure_lock})
        wr(8'h31, 8'h50);
        `CHK("lock_or", 3'h3, secure_lock)
        cmd(8'h06);
        cmd(8'hC7);
        `CHK("chip_go", 2'h3, {chip_wipe_start, busy_flag})
        done_op();
    endtask : s_protect

    task automatic s_suspend();
        cmd(8'h06);
        cmd(8'h02, 8'h00, 24'h000100);
        `CHK("prog_go", 2'h3, {prog_start, busy_flag})
        cmd(8'h75);
        `CHK("p_pause", 2'h2, {status_word[10], busy_flag})
        cmd(8'h7A);
        `CHK("p_resume", 2'h1, {status_word[10], busy_flag})
        done_op();
        cmd(8'h06);
        cmd(8'h20, 8'h00, 24'h002000);
        `CHK("erase_go", 1'b1, erase_start)
        cmd(8'h75);
        `CHK("e_pause", 2'h2, {status_word[15], status_word[10]})
        cmd(8'h66);
        cmd(8'h99);
        `CHK("e_reset", 3'h0, {status_word[15], busy_flag, write_latch})
    endtask : s_suspend

    task automatic s_drive();
        for (int d = 0; d < 4; d++) begin
            wr(8'h11, {1'b0, d[1:0], 5'h00});
            `CHK("drive", d[1:0], drive_strength)
        end
        wr(8'h11, 8'h9F);
        `CHK("byte3", 8'h84, status_word[23:16])
        `CHK("pins", 3'h5, {low_power_state, pause_enable, reset_enable})
        cmd(8'h06);
        @(posedge clk);
        shared_n_pin <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK("pin_rst", 2'h1, {write_latch, soft_reset})
        @(posedge clk);
        shared_n_pin <= 1'b1;
        repeat (2) @(posedge clk);
        wr(8'h11, 8'h40);
    endtask : s_drive

    task automatic s_guard();
        wr(8'h01, 8'h9C);
        pin(1'b0);
        wr(8'h01, 8'h80);
        `CHK("hw_lock", 7'h27, status_word[8:2])
        pin(1'b1);
        wr(8'h01, 8'h80);
        `CHK("hw_open", 5'h00, status_word[6:2])
        wr(8'h01, 8'h00);
        wr(8'h31, 8'h41);
        wr(8'h01, 8'h1C);
        `CHK("sg10_lock", 7'h40, status_word[8:2])
        pwr();
        `CHK("sg_cycle", 24'h400000, status_word)
        pin(1'b0);
        wr(8'h01, 8'h9C);
        `CHK("sg00_pinlow", 6'h27, status_word[7:2])
        wr(8'h31, 8'h03);
        `CHK("quad_pinlow", 1'b0, quad_lane_switch)
        pin(1'b1);
        wr(8'h31, 8'h03);
        `CHK("quad", 3'h4, {quad_lane_switch, pause_enable, reset_enable})
        wr(8'h01, 8'h00);
        `CHK("sg11_lock", 7'h67, status_word[8:2])
    endtask : s_guard

    initial begin
        pwr();
        s_defaults();
        s_latch();
        s_protect();
        s_suspend();
        s_drive();
        s_guard();
        give_verdict();
    end
endmodule : testbench

bind fsr_status_word fsr_status_word_assertions #(.SRW_CYCLES(SRW_CYCLES)) chk (.clk, .rst_n,
    .cmd_valid, .cmd_code, .cmd_aligned, .cmd_addr, .cmd_data, .op_done, .wp_n_pin,
    .shared_n_pin, .status_word, .busy_flag, .write_latch, .quad_lane_switch, .drive_strength,
    .secure_lock, .low_power_state, .pause_enable, .reset_enable, .pause_active, .prog_start,
    .erase_start, .chip_wipe_start, .array_run, .soft_reset);

`default_nettype wire
